// file: hdl/sbs_burst_ctr.sv
// two-bit burst address counter with linear and interleaved order
// assumes load and advance come from the same clock as the counter
`timescale 1ns/1ps
`default_nettype none

module sbs_burst_ctr (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic advance,
   input wire logic [sbs_pkg::BURST_W-1:0] start,
   input wire logic interleave,
   output logic [sbs_pkg::BURST_W-1:0] addr_low
);
   import sbs_pkg::*;

   // ****************************************
   // next address in either order
   // ****************************************
   function automatic logic [BURST_W-1:0] sbs_burst_addr(
      input logic [BURST_W-1:0] base,
      input logic [BURST_W-1:0] step,
      input logic ilv
   );
      logic [BURST_W-1:0] res;
      res = ilv ? (base ^ step) : BURST_W'(base + step);
      return res;
   endfunction

   logic [BURST_W-1:0] start_reg;
   logic [BURST_W-1:0] step_reg;
   logic [BURST_W-1:0] start_next;
   logic [BURST_W-1:0] step_next;

   // ****************************************
   // preset on load, step on advance, else hold
   // ****************************************
   assign start_next = load ? start : start_reg;
   // two-bit step wraps so the fifth address equals the first
   assign step_next = load ? '0 : (advance ? BURST_W'(step_reg + 1'b1) : step_reg);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         start_reg <= '0;
         step_reg <= '0;
      end else begin
         start_reg <= start_next;
         step_reg <= step_next;
      end
   end

   assign addr_low = sbs_burst_addr(start_reg, step_reg, interleave);

endmodule // sbs_burst_ctr

`default_nettype wire

// file: hdl/sbs_sram_ctrl.sv
// synchronous burst sram control: pin decode, burst addressing, pipelined read
// path, asynchronous output enable and an ahb-lite register slave
// assumes the sram bus runs on clk and the storage array answers reads in one cycle
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module sbs_sram_ctrl (
   input wire logic clk,
   input wire logic nrst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // synchronous sram bus
   input wire logic [sbs_pkg::ADDR_W-1:0] addr_in,
   input wire logic chip_select_n,
   input wire logic cpu_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic lane_a_write_n,
   input wire logic lane_b_write_n,
   input wire logic lane_c_write_n,
   input wire logic lane_d_write_n,
   input wire logic burst_order_sel_n,
   // asynchronous pins
   input wire logic sleep_request,
   input wire logic out_enable_n,
   // data lanes, split into in, out and low-active enable per lane
   input wire logic [sbs_pkg::DATA_W-1:0] dq_in,
   output logic [sbs_pkg::DATA_W-1:0] dq_out,
   output logic [sbs_pkg::LANES-1:0] dq_oe_n,
   // storage array port
   output logic [sbs_pkg::ADDR_W-1:0] mem_addr,
   output logic [sbs_pkg::DATA_W-1:0] mem_wdata,
   output logic [sbs_pkg::LANES-1:0] mem_we,
   output logic mem_rd,
   input wire logic [sbs_pkg::DATA_W-1:0] mem_rdata
);
   import sbs_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [CNT_W-1:0] rd_cnt_reg;
   logic [CNT_W-1:0] rd_cnt_next;
   logic [CNT_W-1:0] wr_cnt_reg;
   logic [CNT_W-1:0] wr_cnt_next;
   logic ahb_wr_pend_reg;
   logic [31:0] ahb_addr_reg;
   logic [31:0] hrdata_reg;
   logic [31:0] hrdata_next;

   logic [SYNC_STAGES-1:0] sleep_sync_reg;
   logic asleep_reg;
   logic asleep_next;
   logic [SYNC_STAGES-1:0] order_sync_reg;
   logic order_reg;
   logic order_next;

   sbs_cyc_e cyc_reg;
   sbs_cyc_e cyc_next;
   logic [LANES-1:0] we_lanes_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [ADDR_W-1:0] addr_hi_reg;
   logic [ADDR_W-1:0] addr_hi_next;
   logic burst_valid_reg;
   logic burst_valid_next;
   logic [DATA_W-1:0] dq_out_reg;
   logic [DATA_W-1:0] dq_out_next;
   logic drive_reg;
   logic drive_next;

   logic [BURST_W-1:0] burst_low;

   // ****************************************
   // ahb-lite slave: zero wait states, always okay
   // ****************************************
   wire logic ahb_take = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
   wire logic ahb_take_wr = ahb_take & hwrite;
   wire logic ahb_take_rd = ahb_take & ~hwrite;
   wire logic [31:0] haddr_word = {haddr[31:2], 2'b00};
   wire logic wr_ctrl = ahb_wr_pend_reg & (ahb_addr_reg == CTRL_OFS);
   wire logic wr_rdcnt = ahb_wr_pend_reg & (ahb_addr_reg == RDCNT_OFS);
   wire logic wr_wrcnt = ahb_wr_pend_reg & (ahb_addr_reg == WRCNT_OFS);
   // a read right behind a write to the control word sees the written value; to a counter word it reads zero
   wire logic rd_fwd = ahb_wr_pend_reg & (ahb_addr_reg == haddr_word);

   wire logic ctrl_en = ctrl_reg[CTRL_EN_BIT];

   wire logic [31:0] stat_word = {24'h00_0000,
                                  order_reg,
                                  burst_valid_reg,
                                  cyc_reg,
                                  burst_low,
                                  drive_reg,
                                  asleep_reg};

   wire logic [31:0] ctrl_fwd = rd_fwd ? (hwdata & CTRL_MASK) : ctrl_reg;
   wire logic [31:0] rdcnt_fwd = rd_fwd ? 32'h0000_0000 : {16'h0000, rd_cnt_reg};
   wire logic [31:0] wrcnt_fwd = rd_fwd ? 32'h0000_0000 : {16'h0000, wr_cnt_reg};

   // unmapped words read zero and ignore writes
   wire logic [31:0] rd_mux =
      (haddr_word == CTRL_OFS) ? ctrl_fwd :
      (haddr_word == STAT_OFS) ? stat_word :
      (haddr_word == RDCNT_OFS) ? rdcnt_fwd :
      (haddr_word == WRCNT_OFS) ? wrcnt_fwd : 32'h0000_0000;

   assign hrdata_next = ahb_take_rd ? rd_mux : hrdata_reg;
   assign ctrl_next = wr_ctrl ? (hwdata & CTRL_MASK) : ctrl_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ahb_wr_pend_reg <= 1'b0;
         ahb_addr_reg <= 32'h0000_0000;
         hrdata_reg <= 32'h0000_0000;
         ctrl_reg <= CTRL_RST;
      end else begin
         ahb_wr_pend_reg <= ahb_take_wr;
         ahb_addr_reg <= ahb_take ? haddr_word : ahb_addr_reg;
         hrdata_reg <= hrdata_next;
         ctrl_reg <= ctrl_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // sleep and burst order pins: three-stage synchronisers
   // ****************************************
   // a new level counts once the second and third stages agree
   function automatic logic sbs_settled(
      input logic [SYNC_STAGES-1:0] stages,
      input logic held
   );
      return (stages[1] == stages[2]) ? stages[2] : held;
   endfunction

   // an unconnected pin is pulled low outside, which selects active operation
   assign asleep_next = sbs_settled(sleep_sync_reg, asleep_reg);
   // order pin high selects interleaved order
   assign order_next = sbs_settled(order_sync_reg, order_reg);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sleep_sync_reg <= '0;
         asleep_reg <= 1'b0;
         order_sync_reg <= '0;
         order_reg <= 1'b0;
      end else begin
         sleep_sync_reg <= {sleep_sync_reg[SYNC_STAGES-2:0], sleep_request};
         asleep_reg <= asleep_next;
         order_sync_reg <= {order_sync_reg[SYNC_STAGES-2:0], burst_order_sel_n};
         order_reg <= order_next;
      end
   end

   // ****************************************
   // synchronous command decode
   // ****************************************
   wire logic active = ctrl_en & ~asleep_reg;
   wire logic cs = ~chip_select_n;
   wire logic start_cpu = cs & ~cpu_addr_strobe_n;
   wire logic start_ctrl = cs & cpu_addr_strobe_n & ~ctrl_addr_strobe_n;
   wire logic desel = chip_select_n & ~ctrl_addr_strobe_n;
   wire logic cont = ctrl_addr_strobe_n & (cpu_addr_strobe_n | chip_select_n);
   wire logic load = active & (start_cpu | start_ctrl);
   wire logic cont_ok = active & cont & burst_valid_reg;
   // dummy reads step the counter exactly like driven reads
   wire logic step = cont_ok & ~burst_advance_n;
   wire logic interleave = order_reg;

   // lanes c and d always present: the block is built only as x36
   wire logic [LANES-1:0] lane_n = {lane_d_write_n,
                                    lane_c_write_n,
                                    lane_b_write_n,
                                    lane_a_write_n};
   wire logic [LANES-1:0] wr_lanes = sbs_write_lanes(global_write_n, byte_write_n, lane_n);
   wire logic is_wr = |wr_lanes;

   always_comb begin
      cyc_next = CYC_DESEL;
      if (!active) begin
         cyc_next = CYC_DESEL;
      end else if (start_cpu) begin
         cyc_next = CYC_READ;
      end else if (start_ctrl || cont_ok) begin
         cyc_next = is_wr ? CYC_WRITE : CYC_READ;
      end else begin
         cyc_next = CYC_DESEL;
      end
   end

   assign burst_valid_next = (!active || desel) ? 1'b0 : (load ? 1'b1 : burst_valid_reg);
   assign addr_hi_next = load ? addr_in : addr_hi_reg;

   // ****************************************
   // burst counter
   // ****************************************
   sbs_burst_ctr u_burst_ctr (
      .clk(clk),
      .nrst(nrst),
      .load(load),
      .advance(step),
      .start(addr_in[BURST_W-1:0]),
      .interleave(interleave),
      .addr_low(burst_low)
   );

   // ****************************************
   // cycle stage: address and write data held one clock
   // ****************************************
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cyc_reg <= CYC_DESEL;
         we_lanes_reg <= '0;
         wdata_reg <= '0;
         addr_hi_reg <= '0;
         burst_valid_reg <= 1'b0;
      end else begin
         cyc_reg <= cyc_next;
         we_lanes_reg <= wr_lanes;
         wdata_reg <= dq_in;
         addr_hi_reg <= addr_hi_next;
         burst_valid_reg <= burst_valid_next;
      end
   end

   // upper bits from the loaded address, low two from the counter
   assign mem_addr = {addr_hi_reg[ADDR_W-1:BURST_W], burst_low};
   assign mem_wdata = wdata_reg;
   assign mem_we = (cyc_reg == CYC_WRITE) ? we_lanes_reg : '0;
   assign mem_rd = (cyc_reg == CYC_READ);

   // ****************************************
   // output stage: read data one edge later
   // ****************************************
   always_comb begin
      dq_out_next = dq_out_reg;
      drive_next = 1'b0;
      unique case (cyc_reg)
         CYC_READ: begin
            dq_out_next = mem_rdata;
            drive_next = ~asleep_reg;
         end
         CYC_WRITE: begin
            drive_next = 1'b0;
         end
         CYC_DESEL: begin
            drive_next = 1'b0;
         end
         default: begin
            drive_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         dq_out_reg <= '0;
         drive_reg <= 1'b0;
      end else begin
         dq_out_reg <= dq_out_next;
         drive_reg <= drive_next;
      end
   end

   assign dq_out = dq_out_reg;
   // output enable gates the drivers without the clock; it cannot turn on a lane
   // that no read has armed
   assign dq_oe_n = {LANES{~(drive_reg & ~out_enable_n)}};

   // ****************************************
   // cycle counters, each cleared by any write to its own word
   // ****************************************
   // a cycle finishing in the clearing clock is still counted
   assign rd_cnt_next = CNT_W'((wr_rdcnt ? CNT_RST : rd_cnt_reg)
                               + ((cyc_reg == CYC_READ) ? CNT_ONE : CNT_RST));
   assign wr_cnt_next = CNT_W'((wr_wrcnt ? CNT_RST : wr_cnt_reg)
                               + ((cyc_reg == CYC_WRITE) ? CNT_ONE : CNT_RST));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rd_cnt_reg <= CNT_RST;
         wr_cnt_reg <= CNT_RST;
      end else begin
         rd_cnt_reg <= rd_cnt_next;
         wr_cnt_reg <= wr_cnt_next;
      end
   end

endmodule // sbs_sram_ctrl

`default_nettype wire

// file: include/sbs_pkg.sv
// constants, cycle types and write decode for the synchronous burst sram control block
// assumes one clock shared by the sram bus and the ahb-lite register port
//
// Behaviour
// - burst order pin low linear, high interleaved
// - sleep input high standby; unconnected means active
// - linear order adds one modulo four
// - interleaved order xors start with step count
// - counter wraps to start on fourth advance
// - byte write writes only enabled lanes
// - reads drive every byte lane
// - writes keep all data lanes floating
// - lanes c and d exist in x36 only
// - chip off with controller strobe deselects
// - chip on, processor strobe: load, read burst
// - controller strobe loads, write if decoded write
// - no strobes, advance low: step counter
// - no strobes, advance high: hold counter
// - output enable acts asynchronously on drivers
// - dummy reads advance counter like normal reads
// - two low address bits preset the counter

package sbs_pkg;

   // ****************************************
   // data path geometry
   // ****************************************
   localparam int ADDR_W = 18;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = 36;
   localparam int BURST_W = 2;
   localparam int CNT_W = 16;
   localparam int SYNC_STAGES = 3;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STAT_OFS = 32'h0000_0004;
   localparam logic [31:0] RDCNT_OFS = 32'h0000_0008;
   localparam logic [31:0] WRCNT_OFS = 32'h0000_000C;

   localparam int CTRL_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0001;

   localparam int STAT_SLEEP_BIT = 0;
   localparam int STAT_DRIVE_BIT = 1;
   localparam int STAT_BURST_LSB = 2;
   localparam int STAT_CYC_LSB = 4;
   localparam int STAT_VALID_BIT = 6;
   localparam int STAT_ORDER_BIT = 7;

   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // ahb-lite transfer type bit that marks nonseq or seq
   localparam int HTRANS_ACTIVE_BIT = 1;

   // ****************************************
   // cycle types, gray along desel-read-write
   // ****************************************
   typedef enum logic [1:0] {
      CYC_DESEL = 2'b00,
      CYC_READ = 2'b01,
      CYC_WRITE = 2'b11
   } sbs_cyc_e;

   // ****************************************
   // byte write decode
   // ****************************************
   function automatic logic [LANES-1:0] sbs_write_lanes(
      input logic gw_n,
      input logic bw_n,
      input logic [LANES-1:0] lane_n
   );
      logic [LANES-1:0] res;
      res = '0;
      if (!gw_n) begin
         res = '1;
      end else if (!bw_n) begin
         res = ~lane_n;
      end else begin
         res = '0;
      end
      return res;
   endfunction

endpackage

// file: verification/sbs_mem_model.sv
// storage array behind the controller: combinational read, lane write
// assumes mem_we and mem_wdata stand for the cycle before the writing edge
`timescale 1ns/1ps
`default_nettype none
module sbs_mem_model (
   input wire logic clk,
   input wire logic [sbs_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [sbs_pkg::DATA_W-1:0] mem_wdata,
   input wire logic [sbs_pkg::LANES-1:0] mem_we,
   input wire logic mem_rd,
   output logic [sbs_pkg::DATA_W-1:0] mem_rdata
);
   import sbs_pkg::*;
   logic [DATA_W-1:0] arr [64];
   logic [DATA_W-1:0] last = '0;
   initial for (int i = 0; i < 64; i++) arr[i] = {6{i[5:0]}} ^ 36'hA_5A5A_5A5A;
   // idle read port shows the inverse of the last word, never a stale match
   assign mem_rdata = mem_rd ? arr[mem_addr[5:0]] : ~last;
   always @(posedge clk) begin
      if (mem_rd) last <= arr[mem_addr[5:0]];
      for (int l = 0; l < LANES; l++)
         if (mem_we[l]) arr[mem_addr[5:0]][l*LANE_W +: LANE_W] <= mem_wdata[l*LANE_W +: LANE_W];
   end
endmodule // sbs_mem_model
`default_nettype wire

// file: verification/sbs_sram_ctrl_sva.sv
// checker for the sram bus decode, burst counter and output drive
// assumes a single clk domain; bound into sbs_sram_ctrl below
`timescale 1ns/1ps
`default_nettype none
module sbs_sram_ctrl_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [sbs_pkg::ADDR_W-1:0] addr_in,
   input wire logic chip_select_n,
   input wire logic cpu_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic lane_a_write_n,
   input wire logic lane_b_write_n,
   input wire logic lane_c_write_n,
   input wire logic lane_d_write_n,
   input wire logic burst_order_sel_n,
   input wire logic sleep_request,
   input wire logic out_enable_n,
   input wire logic [sbs_pkg::DATA_W-1:0] dq_out,
   input wire logic [sbs_pkg::LANES-1:0] dq_oe_n,
   input wire logic [sbs_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [sbs_pkg::LANES-1:0] mem_we,
   input wire logic mem_rd,
   input wire logic [sbs_pkg::DATA_W-1:0] mem_rdata
);
   import sbs_pkg::*;
   // ****
   // enable bit and sleep history seen from the ports
   // ****
   logic en_reg;
   logic pend_reg;
   logic [3:0] slp_reg;
   wire ok = en_reg && slp_reg == 4'h0 && !sleep_request;
   wire cs = !chip_select_n;
   wire ld = cs && (!cpu_addr_strobe_n || !ctrl_addr_strobe_n);
   wire cld = cs && cpu_addr_strobe_n && !ctrl_addr_strobe_n;
   wire cont = ctrl_addr_strobe_n && (cpu_addr_strobe_n || !cs);
   wire [3:0] ln = {lane_d_write_n, lane_c_write_n, lane_b_write_n, lane_a_write_n};
   always_ff @(posedge clk) begin
      if (!nrst) begin
         en_reg <= 1'b1;
         pend_reg <= 1'b0;
         slp_reg <= 4'h0;
      end else begin
         pend_reg <= hsel && hready && htrans[1] && hwrite && haddr == CTRL_OFS;
         slp_reg <= {slp_reg[2:0], sleep_request};
         if (pend_reg) begin
            en_reg <= hwdata[CTRL_EN_BIT];
         end
      end
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   oe_async_a: assert property (out_enable_n |-> dq_oe_n == 4'hF)
      else $error("lanes driven with oe high");
   wr_float_a: assert property (|mem_we |=> dq_oe_n == 4'hF)
      else $error("lanes driven after write");
   rd_drive_a: assert property (ok && mem_rd && !out_enable_n ##1 !out_enable_n
      |-> dq_oe_n == 4'h0)
      else $error("read not driving all lanes");
   rd_pipe_a: assert property (mem_rd |=> dq_out == $past(mem_rdata))
      else $error("read data not one cycle later");
   gw_all_a: assert property (ok && cld && !global_write_n |=> mem_we == 4'hF)
      else $error("global write not all lanes");
   bw_lane_a: assert property (ok && cld && global_write_n
      |=> mem_we == $past(byte_write_n ? 4'h0 : ~ln))
      else $error("byte lane decode wrong");
   cpu_rd_a: assert property (ok && cs && !cpu_addr_strobe_n
      |=> mem_rd && mem_we == 4'h0 && mem_addr == $past(addr_in))
      else $error("cpu strobe not a read load");
   desel_a: assert property (chip_select_n && !ctrl_addr_strobe_n
      |=> !mem_rd && mem_we == 4'h0 ##1 dq_oe_n == 4'hF)
      else $error("deselect not idle");
   lin_step_a: assert property (ok && ld ##1 ok && cont && !burst_advance_n
      && !burst_order_sel_n |=> mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1)
      else $error("linear step wrong");
   hold_a: assert property (ok && ld ##1 ok && cont && burst_advance_n
      |=> mem_addr == $past(mem_addr))
      else $error("suspend moved address");
   sleep_a: assert property (sleep_request [*6] |=> !mem_rd && mem_we == 4'h0)
      else $error("access while asleep");
   cover property (ok && ld ##1 cont [*4]);
   cover property (|mem_we ##1 mem_rd);
   cover property (mem_rd ##1 out_enable_n);
endmodule // sbs_sram_ctrl_chk
bind sbs_sram_ctrl sbs_sram_ctrl_chk sbs_sram_ctrl_chk_inst (.*);
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for sbs_sram_ctrl with the storage array model
// assumes zero-wait ahb-lite slave and one-cycle array reads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sbs_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, mem_rd;
   logic [ADDR_W-1:0] addr_in = '0, mem_addr;
   logic chip_select_n = 1'b1, cpu_addr_strobe_n = 1'b1, ctrl_addr_strobe_n = 1'b0;
   logic burst_advance_n = 1'b1, global_write_n = 1'b1, byte_write_n = 1'b1;
   logic lane_a_write_n = 1'b1, lane_b_write_n = 1'b1, lane_c_write_n = 1'b1;
   logic lane_d_write_n = 1'b1, burst_order_sel_n = 1'b0, sleep_request = 1'b0;
   logic out_enable_n = 1'b0;
   logic [DATA_W-1:0] dq_in = '0, dq_out, mem_wdata, mem_rdata;
   logic [LANES-1:0] dq_oe_n, mem_we;
   logic [31:0] d;
   int n_fail = 0, compares = 0;
   // command words: oe, cs, cpu, ctrl, adv, gw, bw, lanes d..a
   localparam logic [10:0] DSL = 11'b0_1101_11_1111;
   localparam logic [10:0] RDC = 11'b0_0011_11_1111;
   localparam logic [10:0] LDR = 11'b0_0101_11_1111;
   localparam logic [10:0] CNT = 11'b0_1110_11_1111;
   localparam logic [10:0] HLD = 11'b0_1111_11_1111;
   localparam logic [5:0] TW [6] = '{6'b01_0000, 6'b11_0000, 6'b10_1111, 6'b10_1110,
      6'b10_0111, 6'b10_1001};
   localparam logic [3:0] TE [6] = '{4'hF, 4'h0, 4'h0, 4'h1, 4'h8, 4'h6};
   assign hready = hreadyout;
   always #4 clk = ~clk;
   sbs_sram_ctrl sbs_sram_ctrl_inst (.*);
   sbs_mem_model sbs_mem_model_inst (.*);
   // ****
   // shared tasks
   // ****
   function automatic logic [35:0] pat(input logic [5:0] i);
      return {6{i}} ^ 36'hA_5A5A_5A5A;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [10:0] c, input logic [17:0] a = '0, input logic [35:0] w = '0);
      @(posedge clk);
      {out_enable_n, chip_select_n, cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
         global_write_n, byte_write_n, lane_d_write_n, lane_c_write_n, lane_b_write_n,
         lane_a_write_n} <= c;
      addr_in <= a;
      dq_in <= w;
      #1;
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      d = hrdata;
   endtask
   task automatic burst(input logic o, input logic [1:0] s);
      @(posedge clk);
      burst_order_sel_n <= o;
      // the order pin passes a synchroniser before the counter sees it
      repeat (2) @(posedge clk);
      cmd(LDR, {16'h0123, s});
      for (int k = 0; k < 5; k++) begin
         cmd(CNT);
         chk(mem_addr, {16'h0123, o ? s ^ k[1:0] : s + k[1:0]});
      end
      cmd(DSL);
   endtask
   // ****
   // scenarios
   // ****
   task automatic test_regs;
      ahb(1'b0, CTRL_OFS, 0);
      chk(d, CTRL_RST);
      ahb(1'b1, 32'h10, 32'hFFFF_FFFF);
      ahb(1'b0, 32'h10, 0);
      chk(d, 32'h0);
      ahb(1'b1, CTRL_OFS, 0);
      cmd(RDC, 18'h3);
      cmd(DSL);
      chk(mem_rd, 1'b0);
      ahb(1'b1, CTRL_OFS, 1);
      ahb(1'b1, RDCNT_OFS, 0);
      cmd(RDC, 18'h1);
      cmd(RDC, 18'h2);
      cmd(DSL);
      ahb(1'b0, RDCNT_OFS, 0);
      chk(d, 32'h2);
      $display("test_regs done");
   endtask
   task automatic test_linear;
      burst(1'b0, 2'h1);
      $display("test_linear done");
   endtask
   task automatic test_interleave;
      burst(1'b1, 2'h1);
      burst(1'b1, 2'h2);
      ahb(1'b0, STAT_OFS, 0);
      chk(d[STAT_ORDER_BIT], 1'b1);
      $display("test_interleave done");
   endtask
   task automatic test_read;
      cmd(LDR, 18'h5);
      cmd(LDR, 18'h6);
      cmd(DSL);
      chk(dq_out, pat(6'h5));
      chk(dq_oe_n, 4'h0);
      cmd({1'b1, DSL[9:0]});
      chk(dq_out, pat(6'h6));
      chk(dq_oe_n, 4'hF);
      cmd(DSL);
      chk(dq_oe_n, 4'hF);
      cmd({1'b1, LDR[9:0]}, 18'h8);
      cmd({1'b1, CNT[9:0]});
      cmd(11'b1_1110_01_1111, 18'h0, 36'h9_8765_4321);
      chk(mem_addr, 18'h9);
      cmd(DSL);
      chk(mem_addr, 18'hA);
      chk(mem_we, 4'hF);
      cmd(RDC, 18'hA);
      cmd(DSL);
      cmd(DSL);
      chk(dq_out, 36'h9_8765_4321);
      $display("test_read done");
   endtask
   task automatic test_writes;
      for (int i = 0; i < 6; i++) begin
         cmd({5'b00101, TW[i]}, 18'h20 + 18'(i), 36'hC_3C3C_3C3C);
         cmd(DSL);
         chk(mem_we, TE[i]);
         chk(mem_rd, TE[i] == 4'h0);
         chk(mem_addr, 18'h20 + 18'(i));
      end
      $display("test_writes done");
   endtask
   task automatic test_hold;
      cmd(LDR, 18'h31);
      cmd(HLD);
      cmd(HLD);
      cmd(DSL);
      chk(mem_addr, 18'h31);
      cmd(CNT);
      cmd(DSL);
      chk(mem_rd, 1'b0);
      chk(dq_oe_n, 4'hF);
      $display("test_hold done");
   endtask
   task automatic test_sleep;
      @(posedge clk);
      sleep_request <= 1'b1;
      repeat (6) cmd(RDC, 18'h3);
      chk(mem_rd, 1'b0);
      @(posedge clk);
      sleep_request <= 1'b0;
      repeat (6) cmd(DSL);
      cmd(RDC, 18'h3);
      cmd(DSL);
      chk(mem_rd, 1'b1);
      $display("test_sleep done");
   endtask
   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      test_regs;
      test_linear;
      test_interleave;
      test_read;
      test_writes;
      test_hold;
      test_sleep;
      end_of_test;
   end
endmodule // tb_top
`default_nettype wire
